// *** serial_link_bist_and_mode_select_bench.sv ***
// Self-checking bench for the self-test and mode-select block
module serial_link_bist_and_mode_select_bench
   import slb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("unexpected %s expected %0h seen %0h", nm, e, g); \
   end \
end
   logic        mclk, link_clk, reset_n, psel, penable, pwrite, pready;
   logic        power_down, pclk_present, st_pin, link_up, irq_src;
   logic        use_osc, mirror, lfreq, repeater, bcompat, aud_en, st_act;
   logic        bc_req, bc_lock, bc_crc, ds_irq, wake;
   logic        slverr, from_test, c18, clk_en, pass;
   logic [2:0]  addr_div, mode_div;
   logic [6:0]  dev_addr, fmax, fmin;
   logic [7:0]  paddr;
   logic [23:0] pixel_in, enc_word;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  rows [8];
   int          n_errors, checks_done, lv;

   always #10 mclk = ~mclk;
   initial begin
      #7;
      forever #80 link_clk = ~link_clk;
   end

   slb_top u_slb_top (
      .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slverr),
      .bc_selftest_req(bc_req), .bc_link_lock(bc_lock),
      .bc_crc_error(bc_crc), .power_down(power_down), .wake_request(wake),
      .pclk_present(pclk_present), .pixel_in(pixel_in),
      .encoder_word(enc_word), .encoder_from_test(from_test),
      .encoder_use_osc(use_osc), .downstream_irq_in(ds_irq),
      .remote_irq_mirror_out(mirror), .address_divider_input(addr_div),
      .mode_divider_input(mode_div), .device_address(dev_addr),
      .low_freq_range(lfreq), .repeater_on(repeater),
      .backward_compat(bcompat), .secondary_audio_data_en(aud_en),
      .colour_18bit(c18), .pclk_max_mhz(fmax), .pclk_min_mhz(fmin),
      .selftest_active(st_act)
   );
   slb_remote_model u_slb_remote_model (
      .link_clk(link_clk), .selftest_enable_pin(st_pin), .link_up(link_up),
      .irq_src(irq_src), .bc_selftest_req(bc_req), .bc_link_lock(bc_lock),
      .bc_crc_error(bc_crc), .downstream_irq_in(ds_irq), .selftest_pass(pass)
   );

   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic give_up;
      n_errors++;
      $display("unexpected wait expected done seen none");
      final_report;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) give_up;
      rdat = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rdat[7:0])
   endtask
   // Selects 0 active, 1 idle, 2 wake
   task automatic wait_for(input int w);
      int i;
      for (i = 0; i < 60; i++) begin
         @(posedge mclk);
         if ((w == 0 ? st_act : w == 1 ? !st_act : wake) === 1'b1) break;
      end
      if (i == 60) give_up;
   endtask
   task automatic do_reset;
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask

   initial begin
      {mclk, link_clk, reset_n, psel, penable, pwrite} = 6'h0;
      {power_down, st_pin, link_up, irq_src} = 4'h0;
      pclk_present = 1'b1;
      clk_en = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      pixel_in = 24'h5aa53c;
      n_errors = 0;
      checks_done = 0;
      rows = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd, 4'ha};
      for (lv = 0; lv < 8; lv++) begin
         addr_div <= lv[2:0];
         mode_div <= lv[2:0];
         do_reset;
         `CHK("addr", 7'h0c + {3'h0, lv[2:0], 1'b0}, dev_addr)
         `CHK("mode", rows[lv], {lfreq, repeater, bcompat, aud_en})
      end
      addr_div <= 3'h0;
      mode_div <= 3'h0;
      do_reset;
      rchk("mode reg", SLB_OFF_MODE, SLB_RST_MODE);
      rchk("compat reg", SLB_OFF_BCOMPAT, SLB_RST_BCOMPAT);
      rchk("pattern reg", SLB_OFF_PATGEN, SLB_RST_PATGEN);
      rchk("unmapped", 8'h40, SLB_UNMAPPED[7:0]);
      `CHK("slverr", 1'b0, slverr)
      apb(1'b1, SLB_OFF_MODE, 32'h0000_0089);
      apb(1'b1, SLB_OFF_BCOMPAT, 32'h0000_0001);
      @(posedge mclk);
      `CHK("mode regs", 4'hb, {lfreq, repeater, bcompat, aud_en})
      `CHK("18-bit", 1'b1, c18)
      `CHK("fmin", 7'h05, fmin)
      `CHK("fmax", 7'h0f, fmax)
      apb(1'b1, SLB_OFF_MODE, 32'h0000_0080);
      @(posedge mclk);
      `CHK("fmin", 7'h0f, fmin)
      `CHK("fmax", 7'h41, fmax)
      st_pin <= 1'b1;
      repeat (40) @(posedge mclk);
      `CHK("blocked", 1'b0, st_act)
      st_pin <= 1'b0;
      irq_src <= 1'b1;
      u_slb_remote_model.send_errors(2);
      `CHK("mirror", 1'b0, mirror)
      apb(1'b1, SLB_OFF_BCOMPAT, 32'h0);
      apb(1'b1, SLB_OFF_MODE, 32'h0);
      link_up <= 1'b1;
      repeat (20) @(posedge mclk);
      `CHK("mirror", 1'b1, mirror)
      `CHK("fmin", 7'h0f, fmin)
      `CHK("fmax", 7'h55, fmax)
      `CHK("18-bit", 1'b0, c18)
      rchk("link", SLB_OFF_LINK, 8'h01);
      rchk("fn count", SLB_OFF_FN_ERR, 8'h00);
      irq_src <= 1'b0;
      u_slb_remote_model.send_errors(2);
      `CHK("mirror", 1'b0, mirror)
      rchk("fn count", SLB_OFF_FN_ERR, 8'h02);
      st_pin <= 1'b1;
      wait_for(0);
      @(posedge mclk);
      `CHK("test word", 24'h0, enc_word)
      `CHK("test source", 1'b1, from_test)
      u_slb_remote_model.send_errors(3);
      rchk("st count", SLB_OFF_ST_ERR, 8'h03);
      rchk("fn count", SLB_OFF_FN_ERR, 8'h02);
      st_pin <= 1'b0;
      wait_for(1);
      repeat (2) @(posedge mclk);
      `CHK("video", 24'h5aa53c, enc_word)
      `CHK("video source", 1'b0, from_test)
      `CHK("pass", 1'b0, pass)
      u_slb_remote_model.send_errors(1);
      rchk("fn count", SLB_OFF_FN_ERR, 8'h03);
      rchk("st count", SLB_OFF_ST_ERR, 8'h03);
      `CHK("pass", 1'b0, pass)
      power_down <= 1'b1;
      st_pin <= 1'b1;
      wait_for(2);
      `CHK("asleep", 1'b0, st_act)
      power_down <= 1'b0;
      wait_for(0);
      rchk("st count", SLB_OFF_ST_ERR, 8'h00);
      st_pin <= 1'b0;
      wait_for(1);
      `CHK("pass", 1'b1, pass)
      pclk_present <= 1'b0;
      apb(1'b1, SLB_OFF_PATGEN, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      `CHK("pattern", 24'h0, enc_word)
      `CHK("osc", 1'b1, use_osc)
      `CHK("pattern source", 1'b1, from_test)
      clk_en <= 1'b0;
      apb(1'b1, SLB_OFF_PATGEN, 32'h0);
      clk_en <= 1'b1;
      rchk("frozen", SLB_OFF_PATGEN, 8'h01);
      final_report;
   end
endmodule

// *** slb_pkg.sv ***
// Shared constants for the serial link self-test and mode-select block
package slb_pkg;
   // Register byte offsets (APB, one word each, word aligned except MODE at 0x12)
   localparam logic [7:0] SLB_OFF_BCOMPAT  = 8'h04;
   localparam logic [7:0] SLB_OFF_LINK     = 8'h0c;
   localparam logic [7:0] SLB_OFF_MODE     = 8'h12;
   localparam logic [7:0] SLB_OFF_STATUS   = 8'h20;
   localparam logic [7:0] SLB_OFF_ST_ERR   = 8'h24;
   localparam logic [7:0] SLB_OFF_FN_ERR   = 8'h28;
   localparam logic [7:0] SLB_OFF_PATGEN   = 8'h2c;
   // Field positions
   localparam int SLB_BIT_BCOMPAT  = 0;
   localparam int SLB_BIT_LINKDET  = 0;
   localparam int SLB_BIT_AUDIO_B  = 0;
   localparam int SLB_BIT_18BIT    = 2;
   localparam int SLB_BIT_LFREQ    = 3;
   localparam int SLB_BIT_REPEAT   = 4;
   localparam int SLB_BIT_OVERRIDE = 7;
   localparam int SLB_BIT_PG_EN    = 0;
   localparam int SLB_BIT_PG_OSC   = 1;
   // Reset values
   localparam logic [7:0] SLB_RST_MODE    = 8'h00;
   localparam logic [7:0] SLB_RST_BCOMPAT = 8'h00;
   localparam logic [7:0] SLB_RST_PATGEN  = 8'h00;
   // Widths and counts
   localparam int SLB_ERR_W      = 8;
   localparam int SLB_LEVELS     = 8;
   localparam int SLB_DIV_W      = 3;
   // Pixel clock range limits in MHz
   localparam int SLB_FMAX_MHZ    = 85;
   localparam int SLB_FMAX_BC_MHZ = 65;
   localparam int SLB_FMIN_MHZ    = 15;
   localparam int SLB_FLOW_MHZ    = 5;
   // Unmapped read answer
   localparam logic [31:0] SLB_UNMAPPED = 32'h0000_0000;
   typedef enum logic [1:0] {
      SLB_NORMAL,
      SLB_WAKE,
      SLB_SELFTEST
   } slb_state_type;
endpackage

// *** slb_remote_model.sv ***
// Behavioural far-end deserializer driving the back-channel levels
module slb_remote_model (
   input  wire logic link_clk,
   input  wire logic selftest_enable_pin,
   input  wire logic link_up,
   input  wire logic irq_src,
   output logic      bc_selftest_req,
   output logic      bc_link_lock,
   output logic      bc_crc_error,
   output logic      downstream_irq_in,
   output logic      selftest_pass
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {bc_selftest_req, bc_link_lock, bc_crc_error} = 3'h0;
      {downstream_irq_in, selftest_pass} = 2'h0;
   end
   always @(posedge link_clk) begin
      bc_selftest_req   <= selftest_enable_pin;
      bc_link_lock      <= link_up;
      downstream_irq_in <= irq_src;
      if (selftest_enable_pin && !bc_selftest_req) begin
         selftest_pass <= 1'b1;
      end
   end
   // One CRC error per two link clocks; a test result drops and stays low
   task automatic send_errors(input int n);
      repeat (n) begin
         @(posedge link_clk);
         bc_crc_error  <= 1'b1;
         selftest_pass <= selftest_pass & ~bc_selftest_req;
         @(posedge link_clk);
         bc_crc_error  <= 1'b0;
      end
   endtask
endmodule

// *** slb_sync3.sv ***
// Three-stage synchroniser with agreement filter for one external level
module slb_sync3 #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   input  wire logic async_in,
   output logic      level_q,
   output logic      rise,
   output logic      fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end else if (clk_en) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Change counts once second and third stages agree
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         level_q <= RESET_VAL;
      end else if (clk_en && (s2_q == s3_q)) begin
         level_q <= s3_q;
      end
   end

   assign rise = clk_en && (s2_q == s3_q) && s3_q && !level_q;
   assign fall = clk_en && (s2_q == s3_q) && !s3_q && level_q;
endmodule

// *** slb_top.sv ***
// Serializer self-test control, error counting, irq mirror and mode decode
// Notes on behaviour
// RULE1: Far end starts test from its enable pin and picks test clock.
// RULE2: On test request, wake if powered down, then send all-zero words.
// RULE3: Far end raises result once locked, pulses low per errored payload. The model raises it at test start and holds it low after an error.
// RULE4: Test ends when far-end enable falls; result then held.
// RULE5: Far end holds result until new test, reset or power down.
// RULE6: After far-end enable falls, return to normal video traffic.
// RULE7: In self test, ignore colour inputs and send an all-zero word.
// RULE8: Test word passes the same scrambler and balance path as video.
// RULE9: Far end compares stream to zero and drives noise pattern.
// RULE10: Count back-channel CRC errors only while link-detect bit is set.
// RULE11: Eight-bit self-test error count, cleared at each test entry.
// RULE12: Test count only in test; functional count resumes on exit.
// RULE13: Pattern generator runs without input, from oscillator if no clock.
// RULE14: Remote irq output follows downstream irq with no register read.
// RULE15: Remote irq output held low until downstream lock.
// RULE16: Address divider decodes to one of eight bus addresses.
// RULE17: Eight pin modes; all settable by register 0x04 and 0x12.
// RULE18: Config from divider level or register bits, four settings.
// RULE19: Low-frequency off gives 15-85 MHz, on gives 5-15; repeater off.
// RULE20: Backward mode gives 15-65 MHz, or 5-15 with low frequency.
// RULE21: Secondary audio selects 18-bit colour with second data input.
// RULE22: Self test unavailable in backward-compatible mode.
// RULE23: Test indication arrives over back channel and starts test.
// RULE24: Leave test at once when back-channel indication withdrawn.
//
// The address map and the APB interface to the registers were decided locally.
module slb_top
   import slb_pkg::*;
#(
   parameter int PIX_W        = 24,
   parameter int ADDR_COUNT   = SLB_LEVELS,
   parameter logic [6:0] ADDR_BASE = 7'h0c
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Back channel status
   input  wire logic             bc_selftest_req,
   input  wire logic             bc_link_lock,
   input  wire logic             bc_crc_error,
   input  wire logic             power_down,
   output logic                  wake_request,
   // Video path
   input  wire logic             pclk_present,
   input  wire logic [PIX_W-1:0] pixel_in,
   output logic [PIX_W-1:0]      encoder_word,
   output logic                  encoder_from_test,
   output logic                  encoder_use_osc,
   // Interrupt mirror
   input  wire logic             downstream_irq_in,
   output logic                  remote_irq_mirror_out,
   // Strap levels, already quantised by the analog comparators
   input  wire logic [SLB_DIV_W-1:0] address_divider_input,
   input  wire logic [SLB_DIV_W-1:0] mode_divider_input,
   // Decoded configuration
   output logic [6:0]            device_address,
   output logic                  low_freq_range,
   output logic                  repeater_on,
   output logic                  backward_compat,
   output logic                  secondary_audio_data_en,
   output logic                  colour_18bit,
   output logic [6:0]            pclk_max_mhz,
   output logic [6:0]            pclk_min_mhz,
   output logic                  selftest_active
);
   slb_state_type state_q;
   logic req_lvl;
   logic req_rise;
   logic req_fall;
   logic lock_lvl;
   logic irq_lvl;
   logic crc_rise;
   logic strap_taken_q;
   logic [SLB_DIV_W-1:0] mode_strap_q;
   logic [SLB_DIV_W-1:0] addr_strap_q;
   logic [7:0] mode_reg_q;
   logic [7:0] bcompat_reg_q;
   logic [7:0] patgen_reg_q;
   logic [SLB_ERR_W-1:0] st_err_q;
   logic [SLB_ERR_W-1:0] fn_err_q;
   logic pin_lf;
   logic pin_rep;
   logic pin_bc;
   logic pin_aud;
   logic wr_en;
   logic rd_en;
   logic entering;

   slb_sync3 u_req (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (bc_selftest_req),
      .level_q  (req_lvl),
      .rise     (req_rise),
      .fall     (req_fall)
   );

   slb_sync3 u_lock (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (bc_link_lock),
      .level_q  (lock_lvl),
      .rise     (),
      .fall     ()
   );

   slb_sync3 u_irq (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (downstream_irq_in),
      .level_q  (irq_lvl),
      .rise     (),
      .fall     ()
   );

   slb_sync3 u_crc (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (bc_crc_error),
      .level_q  (),
      .rise     (crc_rise),
      .fall     ()
   );

   // Strap capture one edge after reset release
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         strap_taken_q <= 1'b0;
         mode_strap_q  <= '0;
         addr_strap_q  <= '0;
      end else if (clk_en && !strap_taken_q) begin
         strap_taken_q <= 1'b1;
         mode_strap_q  <= mode_divider_input;
         addr_strap_q  <= address_divider_input;
      end
   end

   // Pin mode table, eight levels
   always_comb begin
      pin_lf  = 1'b0;
      pin_rep = 1'b0;
      pin_bc  = 1'b0;
      pin_aud = 1'b0;
      unique case (mode_strap_q) // [RULE17]
         3'd0: begin
         end
         3'd1: pin_rep = 1'b1;
         3'd2: begin
            pin_rep = 1'b1;
            pin_aud = 1'b1;
         end
         3'd3: pin_lf = 1'b1;
         3'd4: begin
            pin_lf  = 1'b1;
            pin_aud = 1'b1;
         end
         3'd5: begin
            pin_lf  = 1'b1;
            pin_rep = 1'b1;
         end
         3'd6: begin
            pin_lf  = 1'b1;
            pin_rep = 1'b1;
            pin_aud = 1'b1;
         end
         3'd7: begin
            pin_lf = 1'b1;
            pin_bc = 1'b1;
         end
      endcase
   end

   // Register override selects register bits over the strap
   always_comb begin
      if (mode_reg_q[SLB_BIT_OVERRIDE]) begin // [RULE18]
         low_freq_range          = mode_reg_q[SLB_BIT_LFREQ];
         repeater_on             = mode_reg_q[SLB_BIT_REPEAT];
         secondary_audio_data_en = mode_reg_q[SLB_BIT_AUDIO_B];
         backward_compat         = bcompat_reg_q[SLB_BIT_BCOMPAT];
      end else begin
         low_freq_range          = pin_lf;
         repeater_on             = pin_rep;
         secondary_audio_data_en = pin_aud;
         backward_compat         = pin_bc;
      end
   end

   // Secondary audio forces 18-bit colour
   assign colour_18bit = secondary_audio_data_en
                       | mode_reg_q[SLB_BIT_18BIT]; // [RULE21]

   always_comb begin
      if (low_freq_range) begin // [RULE19]
         pclk_min_mhz = 7'(SLB_FLOW_MHZ);
         pclk_max_mhz = 7'(SLB_FMIN_MHZ);
      end else if (backward_compat) begin // [RULE20]
         pclk_min_mhz = 7'(SLB_FMIN_MHZ);
         pclk_max_mhz = 7'(SLB_FMAX_BC_MHZ);
      end else begin
         pclk_min_mhz = 7'(SLB_FMIN_MHZ);
         pclk_max_mhz = 7'(SLB_FMAX_MHZ);
      end
   end

   // Eight addresses, even steps above the base
   assign device_address = ADDR_BASE
      + 7'({addr_strap_q, 1'b0} % (2 * ADDR_COUNT)); // [RULE16]

   // Self-test sequencing
   assign entering = (state_q == SLB_WAKE) && !power_down;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= SLB_NORMAL;
      end else if (clk_en) begin
         unique case (state_q)
            SLB_NORMAL: begin
               if (req_lvl && !backward_compat) begin // [RULE22] [RULE23]
                  state_q <= SLB_WAKE;
               end
            end
            SLB_WAKE: begin
               if (!req_lvl || backward_compat) begin
                  state_q <= SLB_NORMAL;
               end else if (!power_down) begin // [RULE2]
                  state_q <= SLB_SELFTEST;
               end
            end
            SLB_SELFTEST: begin
               if (!req_lvl || backward_compat) begin // [RULE4] [RULE6] [RULE24]
                  state_q <= SLB_NORMAL;
               end
            end
         endcase
      end
   end

   assign selftest_active = (state_q == SLB_SELFTEST);
   assign wake_request    = (state_q == SLB_WAKE) && power_down; // [RULE2]

   // Encoder feed; scrambler and balance encoder follow for both sources
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         encoder_word      <= '0;
         encoder_from_test <= 1'b0;
         encoder_use_osc   <= 1'b0;
      end else if (clk_en) begin
         encoder_from_test <= selftest_active
                            | (patgen_reg_q[SLB_BIT_PG_EN] & !power_down);
         encoder_use_osc   <= patgen_reg_q[SLB_BIT_PG_OSC]
                            | !pclk_present; // [RULE13]
         if (selftest_active) begin
            encoder_word <= '0; // [RULE7] [RULE8]
         end else if (patgen_reg_q[SLB_BIT_PG_EN] && !power_down) begin
            encoder_word <= '0; // [RULE13]
         end else begin
            encoder_word <= pixel_in;
         end
      end
   end

   // Self-test CRC counter, cleared on entry, saturating
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_err_q <= '0;
      end else if (clk_en) begin
         if (entering) begin
            st_err_q <= '0; // [RULE11]
         end else if (selftest_active && lock_lvl && crc_rise
                      && st_err_q != '1) begin // [RULE10] [RULE12]
            st_err_q <= st_err_q + 1'b1;
         end
      end
   end

   // Functional CRC counter, clear-on-write
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fn_err_q <= '0;
      end else if (clk_en) begin
         if (!selftest_active && lock_lvl && crc_rise
             && fn_err_q != '1) begin // [RULE10] [RULE12]
            fn_err_q <= fn_err_q + 1'b1;
         end else if (wr_en && paddr == SLB_OFF_FN_ERR) begin
            fn_err_q <= '0;
         end
      end
   end

   // Interrupt mirror, low until locked
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         remote_irq_mirror_out <= 1'b0;
      end else if (clk_en) begin
         remote_irq_mirror_out <= lock_lvl & irq_lvl; // [RULE14] [RULE15]
      end
   end

   // APB slave, zero wait states
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = clk_en && psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg_q    <= SLB_RST_MODE;
         bcompat_reg_q <= SLB_RST_BCOMPAT;
         patgen_reg_q  <= SLB_RST_PATGEN;
      end else if (wr_en) begin
         unique case (paddr)
            SLB_OFF_MODE:    mode_reg_q    <= pwdata[7:0]; // [RULE17]
            SLB_OFF_BCOMPAT: bcompat_reg_q <= pwdata[7:0]; // [RULE17]
            SLB_OFF_PATGEN:  patgen_reg_q  <= pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // Read data latched in the setup cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= '0;
      end else if (clk_en && rd_en) begin
         unique case (paddr)
            SLB_OFF_MODE:    prdata <= {24'h0, mode_reg_q};
            SLB_OFF_BCOMPAT: prdata <= {24'h0, bcompat_reg_q};
            SLB_OFF_PATGEN:  prdata <= {24'h0, patgen_reg_q};
            SLB_OFF_LINK:    prdata <= {31'h0, lock_lvl}; // [RULE10]
            SLB_OFF_STATUS:  prdata <= {24'h0, 1'b0, pin_bc, pin_aud,
                                        pin_lf, pin_rep, backward_compat,
                                        selftest_active, req_lvl};
            SLB_OFF_ST_ERR:  prdata <= {24'h0, st_err_q};
            SLB_OFF_FN_ERR:  prdata <= {24'h0, fn_err_q};
            default:         prdata <= SLB_UNMAPPED;
         endcase
      end
   end
endmodule

// *** slb_top_chk.sv ***
// Assertions on self-test, irq mirror and mode decode at the top ports
module slb_top_chk #(
   parameter int PIX_W = 24
) (
   input wire logic             mclk,
   input wire logic             reset_n,
   input wire logic             clk_en,
   input wire logic             power_down,
   input wire logic             bc_selftest_req,
   input wire logic             bc_link_lock,
   input wire logic             downstream_irq_in,
   input wire logic             remote_irq_mirror_out,
   input wire logic [PIX_W-1:0] encoder_word,
   input wire logic             selftest_active,
   input wire logic             backward_compat,
   input wire logic             low_freq_range,
   input wire logic             secondary_audio_data_en,
   input wire logic             colour_18bit,
   input wire logic [6:0]       pclk_max_mhz
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_mirror_unlocked: assert property (
      (clk_en && !bc_link_lock)[*8] |-> !remote_irq_mirror_out)
      else $error("irq mirror high without lock");
   a_mirror_follow: assert property (
      (clk_en && bc_link_lock && downstream_irq_in)[*8]
      |-> remote_irq_mirror_out) else $error("irq mirror not raised");
   a_test_entry: assert property (
      (clk_en && bc_selftest_req && !power_down && !backward_compat)[*8]
      |-> selftest_active) else $error("self test not entered");
   a_test_exit: assert property (
      (clk_en && !bc_selftest_req)[*8] |-> !selftest_active)
      else $error("self test not left");
   a_test_word: assert property (
      selftest_active && clk_en |=> encoder_word == '0)
      else $error("test word not zero");
   a_compat_blocks: assert property (
      backward_compat && clk_en |=> !selftest_active)
      else $error("self test in backward mode");
   a_freq_range: assert property (
      pclk_max_mhz == (low_freq_range ? 7'h0f : backward_compat ? 7'h41
      : 7'h55)) else $error("wrong pixel clock limit");
   a_audio_colour: assert property (
      secondary_audio_data_en |-> colour_18bit)
      else $error("second audio without 18-bit mode");
   c_test_run: cover property ($rose(selftest_active));
   c_mirror_up: cover property ($rose(remote_irq_mirror_out));
   c_compat_req: cover property (backward_compat && bc_selftest_req);
endmodule

bind slb_top slb_top_chk #(.PIX_W(PIX_W)) u_slb_top_chk (
   .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
   .power_down(power_down), .bc_selftest_req(bc_selftest_req),
   .bc_link_lock(bc_link_lock), .downstream_irq_in(downstream_irq_in),
   .remote_irq_mirror_out(remote_irq_mirror_out),
   .encoder_word(encoder_word), .selftest_active(selftest_active),
   .backward_compat(backward_compat), .low_freq_range(low_freq_range),
   .secondary_audio_data_en(secondary_audio_data_en),
   .colour_18bit(colour_18bit), .pclk_max_mhz(pclk_max_mhz)
);
